// File: core/eplc_core.sv
// eplc_core: interrupt latch and arbitration, break entry, flag protection,
// wait/stop sequencing with stop recovery counter, and the register file.
// assumes the cpu core reports instruction boundaries and low-power opcodes
// as one-cycle pulses, and that reset sources arrive as level flags.
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ns
module eplc_core
	import eplc_pkg::*;
(
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	input  wire logic                    hsel,
	input  wire logic [7:0]              haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic      [31:0]             hrdata,
	output logic                         hreadyout,
	output logic                         hresp,
	input  wire logic [EPLC_NUM_IRQ-1:0] irq_req,
	input  wire logic [EPLC_NUM_IRQ-1:0] irq_enable,
	input  wire logic                    mask_flag,
	input  wire logic                    insn_done,
	input  wire logic                    trap_insn,
	input  wire logic                    return_from_interrupt,
	input  wire logic                    wait_insn,
	input  wire logic                    stop_insn,
	input  wire logic                    break_req,
	input  wire logic                    break_exit,
	input  wire logic                    clear_step2,
	input  wire eplc_rst_src_t           rst_src,
	input  wire logic                    sys_reset,
	output logic                         stack_start,
	output logic                         stack_pc_minus_one,
	output logic                         stack_upper_index,
	output logic                         set_mask,
	output logic                         clear_mask,
	output logic [3:0]                   vector_sel,
	output logic                         break_active,
	output logic                         flag_clear_ok,
	output logic                         cpu_clk_en,
	output logic                         periph_clk_en,
	output logic                         base_clock_out_en,
	output logic                         crystal_clock_en,
	output logic                         watchdog_run,
	output logic                         sys_counter_rst
);
	eplc_state_t    state_reg, state_next;
	logic [3:0]     latched_reg, latched_next;
	logic           trap_reg;
	logic [12:0]    count_reg;
	logic [7:0]     brk_stat_reg, brk_ctrl_reg, option_reg;
	eplc_rst_src_t  cause_reg;
	logic           in_break_reg;
	logic           step1_reg;
	logic           wake_by_break_reg;
	logic           wr_ph_reg;
	logic [7:0]     addr_ph_reg;

	function automatic logic [3:0] eplc_prio(input logic [EPLC_NUM_IRQ-1:0] req);
		logic [3:0] v;
		v = EPLC_NO_VECTOR;
		for (int i = EPLC_NUM_IRQ - 1; i >= 0; i--) begin
			if (req[i]) begin
				v = 4'(i);
			end
		end
		return v;
	endfunction

	// gated requests: masked or disabled sources fall through to the next insn
	wire [EPLC_NUM_IRQ-1:0] eligible   = irq_req & irq_enable & {EPLC_NUM_IRQ{~mask_flag}};
	wire [3:0]              winner     = eplc_prio(eligible);
	wire                    hw_take    = insn_done && winner != EPLC_NO_VECTOR;
	wire                    soft_take  = trap_insn || break_req;
	wire                    wake_any   = |(irq_req & irq_enable) || break_req;
	wire [12:0]             rec_len    = option_reg[EPLC_BIT_SHORT_REC] ?
	                                     13'(EPLC_REC_SHORT) : 13'(EPLC_REC_LONG);
	wire                    rec_done   = count_reg >= rec_len - 13'h0001;

	always_comb begin
		state_next   = state_reg;
		latched_next = latched_reg;
		unique case (state_reg)
			EPLC_RUN: begin
				if (soft_take) begin
					latched_next = {1'b0, EPLC_TRAP_VECTOR};
					state_next   = EPLC_ENTRY;
				end else if (stop_insn) begin
					state_next = EPLC_STOP;
				end else if (wait_insn) begin
					state_next = EPLC_WAIT;
				end else if (hw_take) begin
					latched_next = winner;
					state_next   = EPLC_ENTRY;
				end
			end
			EPLC_ENTRY: begin
				state_next = EPLC_SVC;
			end
			EPLC_SVC: begin
				// latched vector holds until return or mask clear
				if (return_from_interrupt || !mask_flag) begin
					latched_next = EPLC_NO_VECTOR;
					state_next   = EPLC_RUN;
				end
			end
			EPLC_WAIT: begin
				if (break_req) begin
					latched_next = {1'b0, EPLC_TRAP_VECTOR};
					state_next   = EPLC_ENTRY;
				end else if (|(irq_req & irq_enable)) begin
					latched_next = eplc_prio(irq_req & irq_enable);
					state_next   = EPLC_ENTRY;
				end
			end
			EPLC_STOP: begin
				if (wake_any) begin
					state_next = EPLC_REC;
				end
			end
			EPLC_REC: begin
				if (rec_done) begin
					latched_next = wake_by_break_reg ? {1'b0, EPLC_TRAP_VECTOR} :
					               eplc_prio(irq_req & irq_enable);
					state_next   = EPLC_ENTRY;
				end
			end
			default: begin
				state_next = EPLC_RUN;
			end
		endcase
	end

	// reset sources bypass arbitration entirely
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg   <= EPLC_RUN;
			latched_reg <= EPLC_NO_VECTOR;
		end else if (sys_reset) begin
			state_reg   <= EPLC_RUN;
			latched_reg <= EPLC_NO_VECTOR;
		end else begin
			state_reg   <= state_next;
			latched_reg <= latched_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trap_reg          <= 1'b0;
			wake_by_break_reg <= 1'b0;
		end else if (state_reg == EPLC_STOP || state_reg == EPLC_WAIT) begin
			wake_by_break_reg <= break_req;
			trap_reg          <= break_req;
		end else if (state_reg == EPLC_RUN) begin
			trap_reg          <= soft_take;
		end
	end

	// counter sits in reset through stop, runs only during recovery
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 13'h0000;
		end else if (state_reg == EPLC_REC) begin
			count_reg <= count_reg + 13'h0001;
		end else begin
			count_reg <= 13'h0000;
		end
	end

	assign stack_start        = state_reg == EPLC_ENTRY;
	assign set_mask           = state_reg == EPLC_ENTRY;
	assign stack_pc_minus_one = stack_start && !trap_reg;
	assign stack_upper_index  = 1'b0;
	assign clear_mask         = state_reg == EPLC_RUN && (wait_insn || stop_insn) &&
	                            !soft_take;
	assign vector_sel         = latched_reg;
	assign cpu_clk_en         = !(state_reg inside {EPLC_WAIT, EPLC_STOP, EPLC_REC});
	assign periph_clk_en      = !(state_reg inside {EPLC_STOP, EPLC_REC});
	assign base_clock_out_en  = state_reg != EPLC_STOP;
	assign crystal_clock_en   = state_reg != EPLC_STOP;
	assign watchdog_run       = !option_reg[EPLC_BIT_NO_WDOG] && state_reg != EPLC_STOP;
	assign sys_counter_rst    = state_reg == EPLC_STOP;
	assign break_active       = in_break_reg;

	// break tracking follows break_req and break_exit; clear protection gated by a single brk_ctrl_reg bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_break_reg <= 1'b0;
		end else if (break_req) begin
			in_break_reg <= 1'b1;
		end else if (break_exit) begin
			in_break_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step1_reg <= 1'b0;
		end else begin
			step1_reg <= in_break_reg;
		end
	end

	// level clear permit, open outside break or while the brk_ctrl_reg bit is set; a clear that happens in break is final
	assign flag_clear_ok = !in_break_reg || brk_ctrl_reg[EPLC_BIT_BRK_CLR];
	wire unused_step = step1_reg & clear_step2;

	// ahb-lite slave: zero wait states, always okay
	wire           ph_valid = hsel && hready && htrans[1];
	wire           rd_cause = ph_valid && !hwrite && haddr == EPLC_OFF_RST_CAUSE;
	wire           wr_stat  = wr_ph_reg && addr_ph_reg == EPLC_OFF_BRK_STAT;
	wire           wr_ctrl  = wr_ph_reg && addr_ph_reg == EPLC_OFF_BRK_CTRL;
	wire           wr_opt   = wr_ph_reg && addr_ph_reg == EPLC_OFF_OPTION;
	wire           wake_set = (state_reg == EPLC_WAIT || state_reg == EPLC_STOP) &&
	                          break_req;
	wire [31:0]    rd_mux   =
		haddr == EPLC_OFF_BRK_STAT  ? {24'h000000, brk_stat_reg} :
		haddr == EPLC_OFF_RST_CAUSE ? {24'h000000, cause_reg, 2'b00} :
		haddr == EPLC_OFF_BRK_CTRL  ? {24'h000000, brk_ctrl_reg} :
		haddr == EPLC_OFF_OPTION    ? {24'h000000, option_reg} :
		haddr == EPLC_OFF_STATUS    ? {24'h000000, 1'(unused_step), latched_reg,
		                               state_reg} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_reg   <= 1'b0;
			addr_ph_reg <= 8'h00;
			hrdata      <= 32'h00000000;
		end else begin
			wr_ph_reg   <= ph_valid && hwrite;
			addr_ph_reg <= haddr;
			if (ph_valid && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			brk_stat_reg <= EPLC_BRK_STAT_RST;
			brk_ctrl_reg <= EPLC_BRK_CTRL_RST;
			option_reg   <= EPLC_OPTION_RST;
		end else if (sys_reset) begin
			brk_stat_reg <= EPLC_BRK_STAT_RST;
			brk_ctrl_reg <= EPLC_BRK_CTRL_RST;
		end else begin
			// set beats a simultaneous write of zero
			if (wake_set) begin
				brk_stat_reg[EPLC_BIT_WAKE] <= 1'b1;
			end else if (wr_stat && !hwdata[EPLC_BIT_WAKE]) begin
				brk_stat_reg[EPLC_BIT_WAKE] <= 1'b0;
			end
			if (wr_ctrl) begin
				brk_ctrl_reg[EPLC_BIT_BRK_CLR] <= hwdata[EPLC_BIT_BRK_CLR];
			end
			if (wr_opt) begin
				option_reg <= hwdata[7:0];
			end
		end
	end

	// cause flags: new reset wins over a coincident read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cause_reg <= eplc_rst_src_t'(EPLC_RST_CAUSE_POR[7:2]);
		end else if (rst_src.por) begin
			cause_reg <= eplc_rst_src_t'(EPLC_RST_CAUSE_POR[7:2]);
		end else if (|rst_src) begin
			cause_reg <= rst_src;
		end else if (rd_cause) begin
			cause_reg <= '0;
		end
	end

	a_entry_stacks: assert property (@(posedge hclk) disable iff (!hresetn)
		stack_start |-> set_mask && !stack_upper_index)
		else $error("entry without mask set");
	a_no_preempt: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_SVC && mask_flag && !return_from_interrupt && !sys_reset
		|=> $stable(vector_sel))
		else $error("latched vector changed");
	a_insn_boundary: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_RUN && !insn_done && !soft_take && !sys_reset
		|=> state_reg != EPLC_ENTRY)
		else $error("entry mid instruction");
	a_mask_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_RUN && mask_flag && !soft_take && !wait_insn && !stop_insn
		|=> state_reg == EPLC_RUN || sys_reset)
		else $error("masked interrupt taken");
	a_trap_pc: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_RUN && trap_insn && !sys_reset
		|=> stack_start && !stack_pc_minus_one && vector_sel == {1'b0, EPLC_TRAP_VECTOR})
		else $error("trap stacked wrong pc");
	a_reset_wins: assert property (@(posedge hclk) disable iff (!hresetn)
		sys_reset |=> state_reg == EPLC_RUN && vector_sel == EPLC_NO_VECTOR)
		else $error("reset arbitrated");
	a_stop_clocks: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_STOP |-> !base_clock_out_en && !crystal_clock_en
		&& sys_counter_rst)
		else $error("clocks running in stop");
	a_short_recover: assert property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_STOP && wake_any && option_reg[EPLC_BIT_SHORT_REC] && !sys_reset
		|=> (state_reg == EPLC_REC)[*8] ##[1:30] stack_start)
		else $error("short recovery wrong");
	a_wake_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		wake_set && !sys_reset |=> brk_stat_reg[EPLC_BIT_WAKE])
		else $error("wake flag not set");
	a_cause_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_cause && !(|rst_src) |=> cause_reg == '0)
		else $error("cause not cleared on read");
	a_break_protect: assert property (@(posedge hclk) disable iff (!hresetn)
		break_req && !brk_ctrl_reg[EPLC_BIT_BRK_CLR] && !wr_ctrl |=> !flag_clear_ok)
		else $error("flag clear allowed in break");
	c_wait_wake: cover property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_WAIT ##1 stack_start);
	c_stop_rec: cover property (@(posedge hclk) disable iff (!hresetn)
		state_reg == EPLC_REC ##1 stack_start);
	c_break_entry: cover property (@(posedge hclk) disable iff (!hresetn)
		break_req ##1 stack_start);
endmodule

// File: core/eplc_pkg.sv
// eplc_pkg: shared constants and types for the exception and low-power controller
// assumes a 32-bit AHB-Lite register bus and a 50 MHz system clock
package eplc_pkg;
	localparam int          EPLC_NUM_IRQ       = 8;
	localparam logic [7:0]  EPLC_OFF_BRK_STAT  = 8'h00;
	localparam logic [7:0]  EPLC_OFF_RST_CAUSE = 8'h04;
	localparam logic [7:0]  EPLC_OFF_BRK_CTRL  = 8'h08;
	localparam logic [7:0]  EPLC_OFF_OPTION    = 8'h0C;
	localparam logic [7:0]  EPLC_OFF_STATUS    = 8'h10;
	localparam int          EPLC_BIT_WAKE      = 1;
	localparam int          EPLC_BIT_BRK_CLR   = 0;
	localparam int          EPLC_BIT_SHORT_REC = 0;
	localparam int          EPLC_BIT_NO_WDOG   = 1;
	localparam logic [7:0]  EPLC_RST_CAUSE_POR = 8'h80;
	localparam logic [7:0]  EPLC_BRK_STAT_RST  = 8'h00;
	localparam logic [7:0]  EPLC_BRK_CTRL_RST  = 8'h00;
	localparam logic [7:0]  EPLC_OPTION_RST    = 8'h00;
	localparam int          EPLC_REC_LONG      = 4096;
	localparam int          EPLC_REC_SHORT     = 32;
	localparam logic [2:0]  EPLC_TRAP_VECTOR   = 3'h7;
	localparam logic [3:0]  EPLC_NO_VECTOR     = 4'hF;

	typedef enum logic [2:0] {
		EPLC_RUN   = 3'b000,
		EPLC_ENTRY = 3'b001,
		EPLC_SVC   = 3'b010,
		EPLC_WAIT  = 3'b011,
		EPLC_STOP  = 3'b100,
		EPLC_REC   = 3'b101
	} eplc_state_t;

	typedef struct packed {
		logic por;
		logic pin;
		logic wdog;
		logic bad_op;
		logic bad_fetch;
		logic brownout;
	} eplc_rst_src_t;

	typedef struct packed {
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [7:0]  haddr;
	} eplc_ahb_req_t;
endpackage

// File: testbench/eplc_cpu_model.sv
// eplc_cpu_model: behavioural cpu core facing the exception controller
// assumes the bench asks for mask set or return through one-cycle requests
`timescale 1ns/1ns
module eplc_cpu_model (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic run,
	input  wire logic ret_req,
	input  wire logic sei_req,
	input  wire logic set_mask,
	input  wire logic clear_mask,
	output logic      mask_flag,
	output logic      insn_done,
	output logic      return_from_interrupt
);
	logic [1:0] phase;
	// mask is set out of reset, as a real core does
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_flag <= 1'b1;
			insn_done <= 1'b0;
			phase <= 2'h0;
			return_from_interrupt <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			insn_done <= run && (phase == 2'h3);
			return_from_interrupt <= ret_req;
			if (set_mask || sei_req)
				mask_flag <= 1'b1;
			else if (clear_mask || ret_req)
				mask_flag <= 1'b0;
		end
	end
endmodule

// File: testbench/tb_top.sv
// tb_top: directed bench for the exception and low-power controller
// assumes a zero-wait bus slave and a cpu model on the far side
`timescale 1ns/1ns
module tb_top;
	import eplc_pkg::*;
	`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
		$display("unexpected at %0t got %0h exp %0h", $time, a, b); end end
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 0, ret = 0, sei = 0;
	logic clear_step2 = 0, sys_reset = 0;
	logic [7:0] haddr = 0, irq_req = 0, irq_enable = 8'hFF;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, rdat;
	logic [4:0] pv = 0;
	eplc_rst_src_t rst_src = '0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, mask_flag, insn_done, rtn, stack_start, pcm1, upper;
	wire set_mask, clear_mask, break_active, flag_ok, cpu_en, per_en, base_en;
	wire xtal_en, wdog, cnt_rst;
	wire [3:0] vector_sel;
	int bad_count = 0, compares = 0, n;
	always #10 hclk = ~hclk;
	eplc_core i_eplc_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.irq_req(irq_req), .irq_enable(irq_enable), .mask_flag(mask_flag),
		.insn_done(insn_done), .trap_insn(pv[0]), .return_from_interrupt(rtn),
		.wait_insn(pv[1]), .stop_insn(pv[2]), .break_req(pv[3]), .break_exit(pv[4]),
		.clear_step2(clear_step2), .rst_src(rst_src), .sys_reset(sys_reset),
		.stack_start(stack_start), .stack_pc_minus_one(pcm1),
		.stack_upper_index(upper), .set_mask(set_mask), .clear_mask(clear_mask),
		.vector_sel(vector_sel), .break_active(break_active), .flag_clear_ok(flag_ok),
		.cpu_clk_en(cpu_en), .periph_clk_en(per_en), .base_clock_out_en(base_en),
		.crystal_clock_en(xtal_en), .watchdog_run(wdog), .sys_counter_rst(cnt_rst));
	eplc_cpu_model i_eplc_cpu_model (.hclk(hclk), .hresetn(hresetn), .run(run),
		.ret_req(ret), .sei_req(sei), .set_mask(set_mask), .clear_mask(clear_mask),
		.mask_flag(mask_flag), .insn_done(insn_done), .return_from_interrupt(rtn));
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rdat = hrdata;
		hsel <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		xfer(0, a, 0);
		d = rdat;
	endtask
	task automatic pls(input logic [4:0] v);
		@(posedge hclk);
		pv <= v;
		@(posedge hclk);
		pv <= 0;
	endtask
	// one-cycle return (r) or mask-set (s) request to the cpu model
	task automatic req(input logic r, input logic s);
		@(posedge hclk);
		ret <= r;
		sei <= s;
		@(posedge hclk);
		ret <= 0;
		sei <= 0;
	endtask
	// counts edges until entry starts, gives up after lim
	task automatic wstk(input int lim);
		n = 0;
		#1;
		while (stack_start !== 1'b1 && n < lim) begin
			@(posedge hclk);
			#1;
			n++;
		end
	endtask
	task automatic t_regs;
		rd(EPLC_OFF_RST_CAUSE, rdat); `CHK(rdat, 32'h80)
		rd(EPLC_OFF_RST_CAUSE, rdat); `CHK(rdat, 32'h0)
		rd(EPLC_OFF_BRK_STAT, rdat); `CHK(rdat, 32'h0)
		rd(8'h20, rdat); `CHK(rdat, 32'h0)
		`CHK(hresp, 1'b0)
		xfer(1, EPLC_OFF_BRK_CTRL, 32'h1);
		rd(EPLC_OFF_BRK_CTRL, rdat); `CHK(rdat, 32'h1)
		xfer(1, EPLC_OFF_BRK_CTRL, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_irq;
		req(1, 0);
		irq_req <= 8'h0A;
		wstk(12); `CHK(n, 12)
		run <= 1;
		wstk(20); `CHK(pcm1, 1'b1)
		`CHK(set_mask, 1'b1)
		`CHK(upper, 1'b0)
		@(posedge hclk);
		#1 `CHK(vector_sel, 4'h1)
		irq_req <= 8'h09;
		wstk(12); `CHK(n, 12)
		irq_req <= 8'h08;
		req(1, 0);
		wstk(20); `CHK(stack_start, 1'b1)
		@(posedge hclk);
		#1 `CHK(vector_sel, 4'h3)
		irq_req <= 0;
		req(1, 0);
		$display("test irq done");
	endtask
	task automatic t_mask;
		req(0, 1);
		irq_req <= 8'h01;
		wstk(16); `CHK(n, 16)
		irq_enable <= 8'h00;
		req(1, 0);
		wstk(16); `CHK(n, 16)
		req(0, 1);
		pls(5'h01);
		wstk(8); `CHK(pcm1, 1'b0)
		@(posedge hclk);
		#1 `CHK(vector_sel, {1'b0, EPLC_TRAP_VECTOR})
		irq_req <= 0;
		irq_enable <= 8'hFF;
		req(1, 0);
		$display("test mask done");
	endtask
	task automatic t_break;
		xfer(1, EPLC_OFF_BRK_CTRL, 32'h1);
		clear_step2 <= 1;
		pls(5'h08);
		wstk(8);
		@(posedge hclk);
		#1 `CHK(vector_sel, {1'b0, EPLC_TRAP_VECTOR})
		`CHK(break_active, 1'b1)
		`CHK(flag_ok, 1'b1)
		xfer(1, EPLC_OFF_BRK_CTRL, 32'h0);
		#1 `CHK(flag_ok, 1'b0)
		pls(5'h10);
		#1 `CHK(flag_ok, 1'b1)
		clear_step2 <= 0;
		req(1, 0);
		$display("test break done");
	endtask
	task automatic t_low;
		req(0, 1);
		pls(5'h02);
		#1 `CHK(mask_flag, 1'b0)
		`CHK({cpu_en, per_en, wdog}, 3'b011)
		xfer(1, EPLC_OFF_OPTION, 32'h2);
		#1 `CHK(wdog, 1'b0)
		@(posedge hclk);
		irq_req <= 8'h04;
		wstk(4); `CHK(n, 1)
		irq_req <= 0;
		req(1, 0);
		pls(5'h02);
		pls(5'h08);
		wstk(8); `CHK(stack_start, 1'b1)
		rd(EPLC_OFF_BRK_STAT, rdat); `CHK(rdat[EPLC_BIT_WAKE], 1'b1)
		xfer(1, EPLC_OFF_BRK_STAT, 32'h0);
		rd(EPLC_OFF_BRK_STAT, rdat); `CHK(rdat, 32'h0)
		pls(5'h10);
		req(1, 0);
		xfer(1, EPLC_OFF_OPTION, 32'h1);
		pls(5'h04);
		#1 `CHK({base_en, xtal_en, cnt_rst}, 3'b001)
		@(posedge hclk);
		irq_req <= 8'h01;
		// wake is seen one edge after wstk starts counting
		wstk(60); `CHK(n, EPLC_REC_SHORT + 1)
		irq_req <= 0;
		req(1, 0);
		xfer(1, EPLC_OFF_OPTION, 32'h0);
		pls(5'h04);
		@(posedge hclk);
		irq_req <= 8'h01;
		wstk(5000); `CHK(n, EPLC_REC_LONG + 1)
		irq_req <= 0;
		req(1, 0);
		$display("test low power done");
	endtask
	task automatic t_rst;
		@(posedge hclk);
		irq_req <= 8'h01;
		sys_reset <= 1;
		rst_src.pin <= 1;
		wstk(10); `CHK(n, 10)
		sys_reset <= 0;
		rst_src <= '0;
		irq_req <= 0;
		rd(EPLC_OFF_RST_CAUSE, rdat); `CHK(rdat, 32'h40)
		rd(EPLC_OFF_RST_CAUSE, rdat); `CHK(rdat, 32'h0)
		$display("test reset done");
	endtask
	task automatic summarize;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		rst_src.por = 1;
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		rst_src <= '0;
		t_regs();
		t_irq();
		t_mask();
		t_break();
		t_low();
		t_rst();
		summarize();
	end
	initial begin
		#200000;
		bad_count++;
		summarize();
	end
endmodule
